// *** dcp_control_pins.sv ***
// Decoder control pins: reset, power-down, strap, serial port, outputs
// Functional notes
// - Serial writes are answered at 0x40 with the strap low and 0x42 high.
// - The reset pin is active low and holds the internal logic in reset.
// - A low power-down pin puts the device into power-down mode.
// - The interrupt output rises when the video condition is detected outside power-down mode.
// - The line-locked pixel clock runs at half the rate of the line-locked source clock.
// - Decoded pixels leave on an eight-bit parallel output bus.
// - Three general-purpose outputs are set through the serial port.
`timescale 1ns/1ps
module dcp_control_pins #(
    parameter int GPO_W = dcp_pkg::GPO_WIDTH,
    parameter int PIX_W = dcp_pkg::PIXEL_WIDTH
) (
    input logic ref_clk,
    input logic reset,
    input logic rst_n_pin,
    input logic power_down_n,
    input logic addr_select_strap,
    input logic scl_in,
    input logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe,
    input logic video_cond,
    output logic irq_out,
    output logic [GPO_W-1:0] gp_outputs,
    output logic core_reset,
    output logic core_power_down,
    input logic pix_clk,
    input logic [PIX_W-1:0] pixel_data_in,
    output logic line_locked_clk,
    output logic [PIX_W-1:0] pixel_bus
);
    logic rst_n_s1_r;
    logic rst_n_s2_r;
    logic pd_n_s1_r;
    logic pd_n_s2_r;
    logic strap_s1_r;
    logic strap_s2_r;
    logic scl_s1_r;
    logic scl_s2_r;
    logic scl_d_r;
    logic sda_s1_r;
    logic sda_s2_r;
    logic sda_d_r;
    logic rst_int_r;
    logic pd_r;
    logic strap_r;
    logic irq_r;
    logic [GPO_W-1:0] gp_r;
    logic [7:0] sub_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [3:0] cnt_r;
    logic oe_r;
    logic out_r;
    dcp_pkg::dcp_sp_state_t st_r;
    logic [7:0] own_wr;
    logic [7:0] own_rd;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic byte_done;

    function automatic logic [8:0] rd_mux(input logic [7:0] a);
        logic [7:0] v;
        v = dcp_pkg::UNMAPPED_READ;
        if (a == dcp_pkg::SUB_GPO) begin
            v = 8'(gp_r);
        end else if (a == dcp_pkg::SUB_STATUS) begin
            v = {dcp_pkg::STATUS_PAD, strap_r, pd_r, irq_r};
        end
        return {~v[7], v};
    endfunction : rd_mux

    // Pin synchronisers; bus idles high
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rst_n_s1_r <= 1'b0;
            rst_n_s2_r <= 1'b0;
            pd_n_s1_r <= 1'b1;
            pd_n_s2_r <= 1'b1;
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            rst_n_s1_r <= rst_n_pin;
            rst_n_s2_r <= rst_n_s1_r;
            pd_n_s1_r <= power_down_n;
            pd_n_s2_r <= pd_n_s1_r;
            strap_s1_r <= addr_select_strap;
            strap_s2_r <= strap_s1_r;
            scl_s1_r <= scl_in;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
            sda_s1_r <= serial_data_pin_in;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
        end
    end

    // Internal reset while the reset pin is low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rst_int_r <= 1'b1;
        end else begin
            rst_int_r <= ~rst_n_s2_r;
        end
    end

    // Power-down mode while the power-down pin is low
    always_ff @(posedge ref_clk) begin
        if (rst_int_r) begin
            pd_r <= 1'b0;
        end else begin
            pd_r <= ~pd_n_s2_r;
        end
    end

    // Strap caught while in reset, held afterwards
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            strap_r <= 1'b0;
        end else if (rst_int_r) begin
            strap_r <= strap_s2_r;
        end
    end

    assign own_wr = strap_r ? dcp_pkg::WR_ADDR_STRAP_HI
                            : dcp_pkg::WR_ADDR_STRAP_LO;
    assign own_rd = own_wr | dcp_pkg::RD_DIR_BIT;

    // Interrupt follows the detected video condition, masked while in power-down
    always_ff @(posedge ref_clk) begin
        if (rst_int_r) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= video_cond & ~pd_r;
        end
    end

    assign scl_rise = scl_s2_r & ~scl_d_r;
    assign scl_fall = ~scl_s2_r & scl_d_r;
    assign bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    assign bus_stop = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
    assign byte_done = scl_fall && (cnt_r == dcp_pkg::BIT_CNT_BYTE);

    // Serial target state, bit shifting and open-drain drive
    always_ff @(posedge ref_clk) begin
        if (rst_int_r) begin
            st_r <= dcp_pkg::DCP_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            oe_r <= 1'b0;
        end else if (bus_start) begin
            st_r <= dcp_pkg::DCP_ADDR;
            cnt_r <= 4'h0;
            oe_r <= 1'b0;
        end else if (bus_stop) begin
            st_r <= dcp_pkg::DCP_IDLE;
            oe_r <= 1'b0;
        end else begin
            unique case (st_r)
                dcp_pkg::DCP_IDLE, dcp_pkg::DCP_IGNORE: begin
                    oe_r <= 1'b0;
                end
                dcp_pkg::DCP_ADDR, dcp_pkg::DCP_SUB,
                dcp_pkg::DCP_DATA: begin
                    if (scl_rise && cnt_r != dcp_pkg::BIT_CNT_BYTE) begin
                        shift_r <= {shift_r[6:0], sda_s2_r};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (byte_done) begin
                        cnt_r <= 4'h0;
                        if (st_r == dcp_pkg::DCP_SUB) begin
                            st_r <= dcp_pkg::DCP_ACK_S;
                            oe_r <= 1'b1;
                        end else if (st_r == dcp_pkg::DCP_DATA) begin
                            st_r <= dcp_pkg::DCP_ACK_D;
                            oe_r <= 1'b1;
                        end else if (shift_r == own_wr ||
                                     shift_r == own_rd) begin
                            st_r <= dcp_pkg::DCP_ACK_A;
                            oe_r <= 1'b1;
                        end else begin
                            st_r <= dcp_pkg::DCP_IGNORE;
                        end
                    end
                end
                dcp_pkg::DCP_ACK_A: begin
                    if (scl_fall) begin
                        cnt_r <= 4'h0;
                        if (shift_r[0]) begin
                            st_r <= dcp_pkg::DCP_RD;
                            {oe_r, tx_r} <= rd_mux(sub_r);
                        end else begin
                            st_r <= dcp_pkg::DCP_SUB;
                            oe_r <= 1'b0;
                        end
                    end
                end
                dcp_pkg::DCP_ACK_S, dcp_pkg::DCP_ACK_D: begin
                    if (scl_fall) begin
                        st_r <= dcp_pkg::DCP_DATA;
                        cnt_r <= 4'h0;
                        oe_r <= 1'b0;
                    end
                end
                dcp_pkg::DCP_RD: begin
                    if (scl_fall) begin
                        if (cnt_r == dcp_pkg::BIT_CNT_LAST_RD) begin
                            st_r <= dcp_pkg::DCP_RD_ACK;
                            cnt_r <= 4'h0;
                            oe_r <= 1'b0;
                        end else begin
                            oe_r <= ~tx_r[6];
                            tx_r <= {tx_r[6:0], 1'b0};
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                end
                dcp_pkg::DCP_RD_ACK: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s2_r};
                    end else if (scl_fall) begin
                        if (shift_r[0]) begin
                            st_r <= dcp_pkg::DCP_IGNORE;
                        end else begin
                            st_r <= dcp_pkg::DCP_RD;
                            {oe_r, tx_r} <= rd_mux(sub_r + 8'h01);
                        end
                    end
                end
            endcase
        end
    end

    // Sub-address pointer, advancing after each written byte and each acknowledged read byte
    always_ff @(posedge ref_clk) begin
        if (rst_int_r) begin
            sub_r <= dcp_pkg::SUB_RESET;
        end else if (st_r == dcp_pkg::DCP_SUB && byte_done) begin
            sub_r <= shift_r;
        end else if (st_r == dcp_pkg::DCP_DATA && byte_done) begin
            sub_r <= sub_r + 8'h01;
        end else if (st_r == dcp_pkg::DCP_RD_ACK && scl_fall &&
                     !shift_r[0]) begin
            sub_r <= sub_r + 8'h01;
        end
    end

    // General-purpose outputs written over the serial port
    always_ff @(posedge ref_clk) begin
        if (rst_int_r) begin
            gp_r <= GPO_W'(dcp_pkg::GPO_RESET);
        end else if (st_r == dcp_pkg::DCP_DATA && byte_done &&
                     sub_r == dcp_pkg::SUB_GPO) begin
            gp_r <= shift_r[GPO_W-1:0];
        end
    end

    // Open-drain data pin only ever pulls low
    always_ff @(posedge ref_clk) begin
        out_r <= 1'b0;
    end

    assign serial_data_pin_out = out_r;
    assign serial_data_pin_oe = oe_r;
    assign irq_out = irq_r;
    assign gp_outputs = gp_r;
    assign core_reset = rst_int_r;
    assign core_power_down = pd_r;

    dcp_pixel_port #(
        .PIX_W(PIX_W)
    ) u_pixel_port (
        .pix_clk(pix_clk),
        .rst_req(rst_int_r),
        .pd_req(pd_r),
        .pixel_data_in(pixel_data_in),
        .line_locked_clk(line_locked_clk),
        .pixel_bus(pixel_bus)
    );

    sequence addr_hit_s;
        st_r == dcp_pkg::DCP_ADDR && byte_done && shift_r == own_wr;
    endsequence
    sequence addr_miss_s;
        st_r == dcp_pkg::DCP_ADDR && byte_done &&
        shift_r != own_wr && shift_r != own_rd;
    endsequence
    sequence rst_pin_held_s;
        (!rst_n_pin) [*3];
    endsequence
    addr_ack_a: assert property (@(posedge ref_clk) disable iff (rst_int_r)
        addr_hit_s |=> (oe_r && st_r == dcp_pkg::DCP_ACK_A))
        else $error("own write address not acknowledged");

    addr_nack_a: assert property (@(posedge ref_clk) disable iff (rst_int_r)
        addr_miss_s |=> (!oe_r && st_r == dcp_pkg::DCP_IGNORE))
        else $error("foreign address acknowledged");

    reset_pin_a: assert property (@(posedge ref_clk) disable iff (reset)
        rst_pin_held_s |=> rst_int_r ##1 (gp_r == '0))
        else $error("reset pin did not reset the logic");

    power_down_a: assert property (@(posedge ref_clk)
        disable iff (rst_int_r)
        (!power_down_n) [*3] |=> pd_r)
        else $error("power-down pin low but mode not entered");

    irq_raise_a: assert property (@(posedge ref_clk) disable iff (rst_int_r)
        (video_cond && !pd_r) |=> irq_r)
        else $error("interrupt not raised on video condition");

    irq_pd_a: assert property (@(posedge ref_clk) disable iff (rst_int_r)
        pd_r [*2] |-> !irq_r)
        else $error("interrupt raised during power-down");

    gpo_write_a: assert property (@(posedge ref_clk) disable iff (rst_int_r)
        (st_r == dcp_pkg::DCP_DATA && byte_done &&
         sub_r == dcp_pkg::SUB_GPO)
        |=> gp_outputs == $past(shift_r[GPO_W-1:0]))
        else $error("general-purpose outputs not written");

    strap_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        !rst_int_r |=> $stable(strap_r))
        else $error("address strap changed outside reset");
endmodule : dcp_control_pins

// *** dcp_control_pins_tb_top.sv ***
// Self-checking testbench for the decoder control pins
`timescale 1ns/1ps
module dcp_control_pins_tb_top;
    logic ref_clk, pix_clk, reset, rst_n_pin, power_down_n;
    logic addr_select_strap, video_cond, scl, host_low, sda;
    logic sda_out, sda_oe, irq_out, core_reset, core_power_down;
    logic line_locked_clk;
    logic [dcp_pkg::GPO_WIDTH-1:0] gp_outputs;
    logic [7:0] pixel_data_in = 8'h00;
    logic [7:0] pixel_bus;
    int fail_count, total_checks;
    // Pulled-up data wire
    assign sda = (host_low | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        pix_clk = 1'b0;
        #37;
        forever #80 pix_clk = ~pix_clk;
    end
    always @(posedge pix_clk) pixel_data_in <= pixel_data_in + 8'h01;
    dcp_control_pins dcp_control_pins_i (
        .ref_clk(ref_clk), .reset(reset), .rst_n_pin(rst_n_pin),
        .power_down_n(power_down_n), .addr_select_strap(addr_select_strap),
        .scl_in(scl), .serial_data_pin_in(sda),
        .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe),
        .video_cond(video_cond), .irq_out(irq_out),
        .gp_outputs(gp_outputs), .core_reset(core_reset),
        .core_power_down(core_power_down), .pix_clk(pix_clk),
        .pixel_data_in(pixel_data_in), .line_locked_clk(line_locked_clk),
        .pixel_bus(pixel_bus)
    );
    dcp_host_model dcp_host_model_i (
        .ref_clk(ref_clk), .sda_in(sda), .scl_out(scl), .sda_low(host_low)
    );
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic wait_core(input logic v);
        for (int i = 0; i < 20; i++) begin
            @(negedge ref_clk);
            if (core_reset === v) return;
        end
        fail_count++;
        $display("[ERR] core_reset expected %h seen %h", v, core_reset);
        stop_test();
    endtask : wait_core
    task automatic reset_dut(input logic s);
        addr_select_strap <= s;
        reset <= 1'b1;
        cyc(4);
        reset <= 1'b0;
        @(negedge ref_clk);
        chk("core_reset", core_reset, 1'b1);
        chk("sda_oe", sda_oe, 1'b0);
        chk("gp_outputs", gp_outputs, 8'h00);
        chk("sda_out", sda_out, 1'b0);
        wait_core(1'b0);
        cyc(4);
    endtask : reset_dut
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic ack);
        logic [7:0] q;
        logic s1, s2, s3;
        dcp_host_model_i.start();
        dcp_host_model_i.xfer(a, 1'b1, q, s1);
        dcp_host_model_i.xfer(dcp_pkg::SUB_GPO, 1'b1, q, s2);
        dcp_host_model_i.xfer(d, 1'b1, q, s3);
        dcp_host_model_i.stop();
        ack = ~(s1 | s2 | s3);
    endtask : wr
    // Two bytes read from sub-address sa onward
    task automatic rd(input logic [7:0] a, input logic [7:0] sa,
                      output logic [7:0] q1, output logic [7:0] q2);
        logic [7:0] q;
        logic s;
        dcp_host_model_i.start();
        dcp_host_model_i.xfer(a, 1'b1, q, s);
        dcp_host_model_i.xfer(sa, 1'b1, q, s);
        dcp_host_model_i.start();
        dcp_host_model_i.xfer(a | dcp_pkg::RD_DIR_BIT, 1'b1, q, s);
        dcp_host_model_i.xfer(8'hFF, 1'b0, q1, s);
        dcp_host_model_i.xfer(8'hFF, 1'b1, q2, s);
        dcp_host_model_i.stop();
    endtask : rd
    task automatic addr_case(input logic s);
        logic ack;
        logic [7:0] own, other, d;
        own = s ? dcp_pkg::WR_ADDR_STRAP_HI : dcp_pkg::WR_ADDR_STRAP_LO;
        other = s ? dcp_pkg::WR_ADDR_STRAP_LO : dcp_pkg::WR_ADDR_STRAP_HI;
        d = s ? 8'h06 : 8'h05;
        reset_dut(s);
        addr_select_strap <= ~s;
        wr(own, d, ack);
        chk("own ack", ack, 1'b1);
        chk("gp_outputs", gp_outputs, d);
        wr(other, 8'h07, ack);
        chk("other ack", ack, 1'b0);
        chk("gp kept", gp_outputs, d);
    endtask : addr_case
    task automatic irq_case();
        cyc(1);
        video_cond <= 1'b1;
        cyc(2);
        @(negedge ref_clk);
        chk("irq_out", irq_out, 1'b1);
        cyc(1);
        video_cond <= 1'b0;
        cyc(2);
        @(negedge ref_clk);
        chk("irq_out", irq_out, 1'b0);
        cyc(1);
        video_cond <= 1'b1;
    endtask : irq_case
    // Strap was 1 at the last reset, outputs hold 6
    task automatic status_case();
        logic [7:0] q1, q2;
        rd(dcp_pkg::WR_ADDR_STRAP_HI, dcp_pkg::SUB_GPO, q1, q2);
        chk("gp read", q1, 8'h06);
        chk("status", q2, 8'h05);
        power_down_n <= 1'b0;
        cyc(5);
        @(negedge ref_clk);
        chk("core_power_down", core_power_down, 1'b1);
        chk("irq in power-down", irq_out, 1'b0);
        rd(dcp_pkg::WR_ADDR_STRAP_HI, dcp_pkg::SUB_STATUS, q1, q2);
        chk("status", q1, 8'h06);
        chk("unmapped read", q2, dcp_pkg::UNMAPPED_READ);
        power_down_n <= 1'b1;
        cyc(5);
        @(negedge ref_clk);
        chk("core_power_down", core_power_down, 1'b0);
    endtask : status_case
    task automatic pixel_case();
        logic old;
        logic [7:0] d;
        repeat (4) @(posedge pix_clk);
        for (int i = 0; i < 8; i++) begin
            @(negedge pix_clk);
            old = line_locked_clk;
            d = pixel_data_in;
            @(posedge pix_clk);
            #1;
            chk("llc", line_locked_clk, (old === 1'b1) ? 1'b0 : 1'b1);
            if (old === 1'b1)
                chk("pixel_bus", pixel_bus, d);
        end
    endtask : pixel_case
    task automatic pin_reset_case();
        cyc(1);
        rst_n_pin <= 1'b0;
        cyc(50000);
        @(negedge ref_clk);
        chk("core_reset", core_reset, 1'b1);
        chk("gp_outputs", gp_outputs, 8'h00);
        chk("llc held", line_locked_clk, 1'b0);
        chk("pixel held", pixel_bus, 8'h00);
        cyc(1);
        rst_n_pin <= 1'b1;
        wait_core(1'b0);
        cyc(10);
    endtask : pin_reset_case
    initial begin
        #7000000;
        fail_count++;
        $display("[ERR] run time expected done seen running");
        stop_test();
    end
    initial begin
        rst_n_pin = 1'b1;
        power_down_n = 1'b1;
        video_cond = 1'b0;
        fail_count = 0;
        total_checks = 0;
        for (int s = 0; s < 2; s++)
            addr_case(s[0]);
        irq_case();
        status_case();
        pixel_case();
        pin_reset_case();
        pixel_case();
        stop_test();
    end
endmodule : dcp_control_pins_tb_top

// *** dcp_host_model.sv ***
// Two-wire bus host model for the decoder control pins
`timescale 1ns/1ps
module dcp_host_model (
    input logic ref_clk,
    input logic sda_in,
    output logic scl_out,
    output logic sda_low
);
    initial begin
        scl_out = 1'b1;
        sda_low = 1'b0;
    end
    // Quarter bit of 7 cycles, 28 cycles a bit, below the clock limit
    task automatic step();
        repeat (7) @(posedge ref_clk);
    endtask : step
    // Start or repeated start; ends with the clock low
    task automatic start();
        step();
        sda_low <= 1'b0;
        step();
        scl_out <= 1'b1;
        step();
        sda_low <= 1'b1;
        step();
        scl_out <= 1'b0;
    endtask : start
    task automatic stop();
        step();
        sda_low <= 1'b1;
        step();
        scl_out <= 1'b1;
        step();
        sda_low <= 1'b0;
        step();
    endtask : stop
    // Data changes only while the clock is low, sampled mid high phase
    task automatic bitx(input logic b, output logic s);
        step();
        sda_low <= ~b;
        step();
        scl_out <= 1'b1;
        step();
        s = sda_in;
        step();
        scl_out <= 1'b0;
    endtask : bitx
    // Eight bits MSB first, then the ninth bit
    task automatic xfer(input logic [7:0] d, input logic b9,
                        output logic [7:0] q, output logic s9);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], s);
            q[i] = s;
        end
        bitx(b9, s9);
    endtask : xfer
endmodule : dcp_host_model

// *** dcp_pixel_port.sv ***
// Line-locked clock and pixel bus stage in the link clock domain
`timescale 1ns/1ps
module dcp_pixel_port #(
    parameter int PIX_W = dcp_pkg::PIXEL_WIDTH
) (
    input logic pix_clk,
    input logic rst_req,
    input logic pd_req,
    input logic [PIX_W-1:0] pixel_data_in,
    output logic line_locked_clk,
    output logic [PIX_W-1:0] pixel_bus
);
    logic rst_s1_r;
    logic rst_s2_r;
    logic pd_s1_r;
    logic pd_s2_r;
    logic hold;
    logic llc_r;
    logic [PIX_W-1:0] pix_r;

    // Level crossing from the reference clock domain
    always_ff @(posedge pix_clk) begin
        rst_s1_r <= rst_req;
        rst_s2_r <= rst_s1_r;
        pd_s1_r <= pd_req;
        pd_s2_r <= pd_s1_r;
    end

    assign hold = rst_s2_r | pd_s2_r;

    // Output clock toggles on each rising edge of the line-locked source (half its rate), stopped low when held
    always_ff @(posedge pix_clk) begin
        if (hold) begin
            llc_r <= 1'b0;
        end else begin
            llc_r <= ~llc_r;
        end
    end

    // Pixel data changes with the falling edge of the output clock
    always_ff @(posedge pix_clk) begin
        if (hold) begin
            pix_r <= PIX_W'(dcp_pkg::PIXEL_RESET);
        end else if (llc_r) begin
            pix_r <= pixel_data_in;
        end
    end

    assign line_locked_clk = llc_r;
    assign pixel_bus = pix_r;

    llc_toggle_a: assert property (@(posedge pix_clk) disable iff (rst_s2_r)
        !hold |=> line_locked_clk == !$past(line_locked_clk))
        else $error("output clock did not toggle");

    pix_load_a: assert property (@(posedge pix_clk) disable iff (rst_s2_r)
        (!hold && line_locked_clk) |=> pixel_bus == $past(pixel_data_in))
        else $error("pixel bus did not load source data");

    pd_quiet_a: assert property (@(posedge pix_clk) disable iff (rst_s2_r)
        pd_s2_r |=> (!line_locked_clk && pixel_bus == '0))
        else $error("pixel port active in power-down");
endmodule : dcp_pixel_port

// *** dcp_pkg.sv ***
// Shared constants and types for the decoder control pin logic
package dcp_pkg;
    // Serial target write addresses selected by the strap
    localparam logic [7:0] WR_ADDR_STRAP_LO = 8'h40;
    localparam logic [7:0] WR_ADDR_STRAP_HI = 8'h42;
    localparam logic [7:0] RD_DIR_BIT = 8'h01;
    // Serial byte framing
    localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_LAST_RD = 4'h7;
    // Sub-addresses reached over the serial port
    localparam logic [7:0] SUB_GPO = 8'h10;
    localparam logic [7:0] SUB_STATUS = 8'h11;
    localparam logic [7:0] SUB_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Field widths and reset values
    localparam int GPO_WIDTH = 3;
    localparam logic [2:0] GPO_RESET = 3'h0;
    localparam int PIXEL_WIDTH = 8;
    localparam logic [7:0] PIXEL_RESET = 8'h00;
    localparam logic [4:0] STATUS_PAD = 5'h00;
    // Timing figures
    localparam int REF_CLK_KHZ = 10000;
    localparam int SCL_MAX_KHZ = 400;
    localparam int SCL_SAMPLES_PER_PERIOD = REF_CLK_KHZ / SCL_MAX_KHZ;

    // Serial port state, Gray coded along the write path
    typedef enum logic [3:0] {
        DCP_IDLE   = 4'h0,
        DCP_ADDR   = 4'h1,
        DCP_ACK_A  = 4'h3,
        DCP_SUB    = 4'h2,
        DCP_ACK_S  = 4'h6,
        DCP_DATA   = 4'h7,
        DCP_ACK_D  = 4'h5,
        DCP_RD     = 4'h4,
        DCP_RD_ACK = 4'hC,
        DCP_IGNORE = 4'h8
    } dcp_sp_state_t;
endpackage : dcp_pkg
